// >>> core/pmbus_cmd_device.sv
`timescale 1ns/1ps
module pmbus_cmd_device (
  input wire logic core_clk,
  input wire logic arst_n,
  pmbus_cmd_if.dev link,
  input wire logic pos_logic_strap,
  input wire logic [pmbus_pkg::FLT_W-2:0] fault_evt,
  output logic [7:0] run_ctrl,
  output logic [7:0] enable_cfg,
  output logic [15:0] vout_target,
  output logic [15:0] freq_set,
  output logic [15:0] vin_on,
  output logic [15:0] vin_off,
  output logic [15:0] ov_limit,
  output logic [pmbus_pkg::FLT_W-1:0] fault_flags
);
  import pmbus_pkg::*;

  logic [15:0] param_reg [N_PARAM];
  logic [15:0] flash_mem [N_PARAM];
  logic [FLT_W-1:0] fault_reg;
  logic [FLT_W-1:0] fault_next;
  logic strap_done_reg;
  logic ack_reg;
  logic nak_reg;
  logic [15:0] rdata_reg;
  logic [3:0] dec;
  logic hit;
  logic [2:0] idx;
  logic [15:0] wval;
  logic [N_PARAM-1:0] range_ok;
  logic is_read;
  logic is_write;
  logic is_send;
  logic do_clr;
  logic do_save;
  logic do_reload;
  logic do_write;
  logic good;
  logic [7:0] strap_cfg;
  logic [2:0] act;
  logic [15:0] rdata_next;

  // the three data-less actions; any other code sent as a send byte is refused
  function automatic logic [2:0] action_of(input logic [7:0] code);
    logic [2:0] a;
    a = 3'h0;
    unique case (code)
      CMD_CLRF: a = 3'b001;
      CMD_SAVE: a = 3'b010;
      CMD_RELOAD: a = 3'b100;
      default: a = 3'h0;
    endcase
    return a;
  endfunction

  assign dec = code_idx(link.code);
  assign hit = dec[3];
  assign idx = dec[2:0];
  assign is_send = link.req && link.send;
  assign is_write = link.req && !link.send && link.wr;
  assign is_read = link.req && !link.send && !link.wr;
  // byte commands only look at the low data byte
  assign wval = (hit && idx <= IX_ENSRC) ? {8'h00, link.wdata[7:0]} : link.wdata;

  genvar gi;
  generate
    for (gi = 0; gi < N_PARAM; gi++) begin : g_chk
      lin_range_check #(
        .L11(IS_L11[gi]),
        .EXP(EXP_VAL[gi]),
        .LO(LO_VAL[gi]),
        .HI(HI_VAL[gi])
      ) u_chk (
        .word(wval),
        .ok(range_ok[gi])
      );
    end
  endgenerate

  assign act = is_send ? action_of(link.code) : 3'h0;
  assign do_clr = act[0];
  assign do_save = act[1];
  assign do_reload = act[2];
  assign do_write = is_write && hit && range_ok[idx];

  // the format byte is readable only; writes to it count as bad data
  always_comb begin
    good = 1'b0;
    if (is_send) begin
      good = |act;
    end else if (is_write) begin
      good = do_write;
    end else if (is_read) begin
      good = hit || link.code == CMD_VFMT;
    end
  end

  assign strap_cfg = pos_logic_strap ? ENSRC_POS : ENSRC_NEG;

  // strap level is caught on the first edge after release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // working parameter table
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N_PARAM; i++) begin
        param_reg[i] <= RST_VAL[i];
      end
    end else if (!strap_done_reg) begin
      param_reg[IX_ENSRC] <= {8'h00, strap_cfg};
    end else if (do_reload) begin
      for (int i = 0; i < N_PARAM; i++) begin
        param_reg[i] <= flash_mem[i];
      end
    end else if (do_write) begin
      param_reg[idx] <= wval;
    end
  end

  // default store, preset to factory values again at every reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N_PARAM; i++) begin
        flash_mem[i] <= RST_VAL[i];
      end
    end else if (!strap_done_reg) begin
      flash_mem[IX_ENSRC] <= {8'h00, strap_cfg};
    end else if (do_save) begin
      for (int i = 0; i < N_PARAM; i++) begin
        flash_mem[i] <= param_reg[i];
      end
    end
  end

  // a new event in the clearing cycle survives the clear
  always_comb begin
    fault_next = do_clr ? '0 : fault_reg;
    fault_next[FLT_W-2:0] = fault_next[FLT_W-2:0] | fault_evt;
    fault_next[FLT_CML] = fault_next[FLT_CML] | (link.req && !good);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // one answer per request, one cycle later
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= link.req;
    end
  end

  // refusal travels with the answer so the host never waits for a second strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nak_reg <= 1'b0;
    end else begin
      nak_reg <= link.req && !good;
    end
  end

  // refused or written requests read back zero; idle cycles keep the last word
  always_comb begin
    rdata_next = rdata_reg;
    if (is_read && hit) begin
      rdata_next = param_reg[idx];
    end else if (is_read && link.code == CMD_VFMT) begin
      rdata_next = {8'h00, VOUT_FORMAT};
    end else if (link.req) begin
      rdata_next = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign link.ack = ack_reg;
  assign link.nak = nak_reg;
  assign link.rdata = rdata_reg;
  assign run_ctrl = param_reg[IX_RUN][7:0];
  assign enable_cfg = param_reg[IX_ENSRC][7:0];
  assign vout_target = param_reg[IX_VOUT];
  assign freq_set = param_reg[IX_FREQ];
  assign vin_on = param_reg[IX_VIN_ON];
  assign vin_off = param_reg[IX_VIN_OFF];
  assign ov_limit = param_reg[IX_OVF];
  assign fault_flags = fault_reg;
endmodule

// >>> core/pmbus_pkg.sv
package pmbus_pkg;
  localparam int N_PARAM = 7;
  localparam logic [7:0] CMD_RUN = 8'h01;
  localparam logic [7:0] CMD_ENSRC = 8'h02;
  localparam logic [7:0] CMD_CLRF = 8'h03;
  localparam logic [7:0] CMD_SAVE = 8'h11;
  localparam logic [7:0] CMD_RELOAD = 8'h12;
  localparam logic [7:0] CMD_VFMT = 8'h20;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_VIN_ON = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF = 8'h36;
  localparam logic [7:0] CMD_OVF = 8'h40;
  localparam logic [7:0] VOUT_FORMAT = 8'h14;
  localparam logic [7:0] ENSRC_NEG = 8'h1d;
  localparam logic [7:0] ENSRC_POS = 8'h1f;
  // five-bit two's complement exponents
  localparam logic [4:0] EXP_VIN = 5'h1d;
  localparam logic [4:0] EXP_IOUT = 5'h1c;
  localparam logic [4:0] EXP_TEMP = 5'h1e;
  localparam logic [4:0] EXP_FREQ = 5'h1e;
  localparam logic [4:0] EXP_TIME = 5'h1f;
  localparam logic [4:0] EXP_NONE = 5'h00;
  // slot indices of the working parameter table
  localparam logic [2:0] IX_RUN = 3'h0;
  localparam logic [2:0] IX_ENSRC = 3'h1;
  localparam logic [2:0] IX_VOUT = 3'h2;
  localparam logic [2:0] IX_FREQ = 3'h3;
  localparam logic [2:0] IX_VIN_ON = 3'h4;
  localparam logic [2:0] IX_VIN_OFF = 3'h5;
  localparam logic [2:0] IX_OVF = 3'h6;
  localparam logic [15:0] RST_VAL [N_PARAM] =
    '{16'h0080, 16'h001d, 16'hbccd, 16'hf208, 16'he910, 16'he900, 16'hf000};
  localparam logic [15:0] LO_VAL [N_PARAM] =
    '{16'h0000, 16'h0000, 16'h999a, 16'h01e0, 16'h0100, 16'h0100, 16'hb000};
  // 16 V does not fit the unsigned word, so the top code is the limit
  localparam logic [15:0] HI_VAL [N_PARAM] =
    '{16'h00ff, 16'h00ff, 16'hd333, 16'h0230, 16'h0170, 16'h0170, 16'hffff};
  localparam logic [N_PARAM-1:0] IS_L11 = 7'b0111000;
  localparam logic [4:0] EXP_VAL [N_PARAM] =
    '{EXP_NONE, EXP_NONE, EXP_NONE, EXP_FREQ, EXP_VIN, EXP_VIN, EXP_NONE};
  localparam logic [10:0] VIN_HYST = 11'h010;
  localparam int FLT_W = 8;
  localparam int FLT_CML = 7;

  // returns {hit, slot}
  function automatic logic [3:0] code_idx(input logic [7:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      CMD_RUN: r = {1'b1, IX_RUN};
      CMD_ENSRC: r = {1'b1, IX_ENSRC};
      CMD_VOUT: r = {1'b1, IX_VOUT};
      CMD_FREQ: r = {1'b1, IX_FREQ};
      CMD_VIN_ON: r = {1'b1, IX_VIN_ON};
      CMD_VIN_OFF: r = {1'b1, IX_VIN_OFF};
      CMD_OVF: r = {1'b1, IX_OVF};
      default: r = 4'h0;
    endcase
    return r;
  endfunction
endpackage

// >>> core/pmbus_cmd_if.sv
`timescale 1ns/1ps
interface pmbus_cmd_if;
  logic req;
  logic wr;
  logic send;
  logic [7:0] code;
  logic [15:0] wdata;
  logic ack;
  logic nak;
  logic [15:0] rdata;
  modport dev(input req, input wr, input send, input code, input wdata,
              output ack, output nak, output rdata);
  modport host(output req, output wr, output send, output code, output wdata,
               input ack, input nak, input rdata);
endinterface

// >>> core/lin_range_check.sv
`timescale 1ns/1ps
module lin_range_check #(
  parameter bit L11 = 1'b0,
  parameter logic [4:0] EXP = 5'h00,
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input wire logic [15:0] word,
  output logic ok
);
  logic exp_ok;
  logic l11_ok;
  logic u16_ok;
  // exponent must match exactly, no rescaling is done
  assign exp_ok = word[15:11] == EXP;
  assign l11_ok = exp_ok && ($signed(word[10:0]) >= $signed(LO[10:0]))
                  && ($signed(word[10:0]) <= $signed(HI[10:0]));
  assign u16_ok = (word >= LO) && (word <= HI);
  assign ok = L11 ? l11_ok : u16_ok;
endmodule

// >>> core/pmbus_cmd_host.sv
`timescale 1ns/1ps
module pmbus_cmd_host (
  input wire logic core_clk,
  input wire logic arst_n,
  pmbus_cmd_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_wr,
  input wire logic cmd_send,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic power_running,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_nak,
  output logic rsp_refused,
  output logic [15:0] rsp_data
);
  import pmbus_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } host_state_t;

  host_state_t state_reg;
  logic req_reg;
  logic wr_reg;
  logic send_reg;
  logic [7:0] code_reg;
  logic [15:0] wdata_reg;
  logic rsp_valid_reg;
  logic rsp_nak_reg;
  logic rsp_refused_reg;
  logic [15:0] rsp_data_reg;
  logic [15:0] sh_vout_reg;
  logic [15:0] sh_on_reg;
  logic [15:0] sh_off_reg;
  logic [15:0] sh_ovf_reg;
  logic take;
  logic refuse;

  assign take = cmd_valid && state_reg == ST_IDLE;

  // shadows hold only what this host wrote; a reload is not tracked
  always_comb begin
    refuse = 1'b0;
    if (cmd_send && cmd_code == CMD_RELOAD) begin
      refuse = power_running;
    end else if (cmd_wr && !cmd_send) begin
      unique case (cmd_code)
        CMD_VIN_ON: refuse = cmd_data[10:0] < sh_off_reg[10:0] + VIN_HYST;
        CMD_VIN_OFF: refuse = cmd_data[10:0] + VIN_HYST > sh_on_reg[10:0];
        CMD_VOUT: refuse = cmd_data >= sh_ovf_reg;
        CMD_OVF: refuse = cmd_data <= sh_vout_reg;
        default: refuse = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      req_reg <= 1'b0;
    end else begin
      req_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (take && !refuse) begin
            req_reg <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link.ack) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= 1'b0;
      send_reg <= 1'b0;
      code_reg <= 8'h00;
      wdata_reg <= 16'h0000;
    end else if (take && !refuse) begin
      wr_reg <= cmd_wr;
      send_reg <= cmd_send;
      code_reg <= cmd_code;
      wdata_reg <= cmd_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_nak_reg <= 1'b0;
      rsp_refused_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= (take && refuse) || (state_reg == ST_WAIT && link.ack);
      rsp_refused_reg <= take && refuse;
      rsp_nak_reg <= state_reg == ST_WAIT && link.ack && link.nak;
      if (state_reg == ST_WAIT && link.ack) begin
        rsp_data_reg <= link.rdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_vout_reg <= RST_VAL[IX_VOUT];
      sh_on_reg <= RST_VAL[IX_VIN_ON];
      sh_off_reg <= RST_VAL[IX_VIN_OFF];
      sh_ovf_reg <= RST_VAL[IX_OVF];
    end else if (state_reg == ST_WAIT && link.ack && !link.nak && wr_reg && !send_reg) begin
      if (code_reg == CMD_VOUT) sh_vout_reg <= wdata_reg;
      if (code_reg == CMD_VIN_ON) sh_on_reg <= wdata_reg;
      if (code_reg == CMD_VIN_OFF) sh_off_reg <= wdata_reg;
      if (code_reg == CMD_OVF) sh_ovf_reg <= wdata_reg;
    end
  end

  assign link.req = req_reg;
  assign link.wr = wr_reg;
  assign link.send = send_reg;
  assign link.code = code_reg;
  assign link.wdata = wdata_reg;
  assign cmd_ready = state_reg[0]; // idle is the low one-hot bit
  assign rsp_valid = rsp_valid_reg;
  assign rsp_nak = rsp_nak_reg;
  assign rsp_refused = rsp_refused_reg;
  assign rsp_data = rsp_data_reg;
endmodule

// >>> tb/pmbus_link_monitor.sv
`timescale 1ns/1ps
module pmbus_link_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic wr,
  input wire logic send,
  input wire logic [7:0] code,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic nak,
  input wire logic [15:0] rdata
);
  import pmbus_pkg::*;
  logic wrq;
  logic rdq;
  assign wrq = req && wr && !send;
  assign rdq = req && !wr && !send;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_ack_next: assert property (req |=> ack)
    else $error("request without answer");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("answer without request");
  a_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data moved between answers");
  a_format_read: assert property (rdq && code == CMD_VFMT |=> !nak && rdata == 16'h0014)
    else $error("format byte wrong");
  a_format_ro: assert property (wrq && code == CMD_VFMT |=> nak)
    else $error("format byte written");
  a_vout_range: assert property (wrq && code == CMD_VOUT
    && (wdata < 16'h999a || wdata > 16'hd333) |=> nak)
    else $error("vout out of range taken");
  a_vin_exp: assert property (wrq && (code == CMD_VIN_ON || code == CMD_VIN_OFF)
    && wdata[15:11] != 5'h1d |=> nak)
    else $error("vin exponent wrong taken");
  a_freq_exp: assert property (wrq && code == CMD_FREQ && wdata[15:11] != 5'h1e |=> nak)
    else $error("freq exponent wrong taken");
  a_send_ok: assert property (req && send
    && (code == CMD_CLRF || code == CMD_SAVE || code == CMD_RELOAD) |=> ack && !nak)
    else $error("send byte refused");
  a_byte_pad: assert property (rdq && code == CMD_RUN |=> rdata[15:8] == 8'h00)
    else $error("byte read not padded");
  c_send: cover property (req && send ##1 ack);
  c_nak: cover property (ack && nak);
  c_write: cover property (wrq ##1 ack && !nak);
endmodule

// >>> tb/test_pmbus_linear_command_decoder.sv
`timescale 1ns/1ps
module test_pmbus_linear_command_decoder;
  import pmbus_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pos_logic_strap = 1'b0;
  logic [6:0] fault_evt = 7'h00;
  logic power_running = 1'b0;
  logic cmd_valid = 1'b0, cmd_wr = 1'b0, cmd_send = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_ready, rsp_valid, rsp_nak, rsp_refused;
  logic [15:0] rsp_data, vout_target, freq_set, vin_on, vin_off, ov_limit;
  logic [7:0] run_ctrl, enable_cfg, fault_flags;
  int n_errors = 0;
  int checks = 0;
  pmbus_cmd_if link_if ();
  pmbus_cmd_device u_pmbus_cmd_device (.core_clk(core_clk), .arst_n(arst_n), .link(link_if),
    .pos_logic_strap(pos_logic_strap), .fault_evt(fault_evt), .run_ctrl(run_ctrl),
    .enable_cfg(enable_cfg), .vout_target(vout_target), .freq_set(freq_set), .vin_on(vin_on),
    .vin_off(vin_off), .ov_limit(ov_limit), .fault_flags(fault_flags));
  pmbus_cmd_host u_pmbus_cmd_host (.core_clk(core_clk), .arst_n(arst_n), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_send(cmd_send), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .power_running(power_running), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_nak(rsp_nak), .rsp_refused(rsp_refused), .rsp_data(rsp_data));
  pmbus_link_monitor u_pmbus_link_monitor (.core_clk(core_clk), .arst_n(arst_n),
    .req(link_if.req), .wr(link_if.wr), .send(link_if.send), .code(link_if.code),
    .wdata(link_if.wdata), .ack(link_if.ack), .nak(link_if.nak), .rdata(link_if.rdata));
  always #25 core_clk = ~core_clk;

  task automatic stop_test();
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // caller enters just after an edge with the host idle
  task automatic xfer(input logic w, input logic s, input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    {cmd_valid, cmd_wr, cmd_send, cmd_code, cmd_data} = {1'b1, w, s, c, d};
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({15'h0, rsp_valid}, 16'h0001);
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic t_defaults();
    logic [7:0] c [8];
    logic [15:0] v [8];
    c = '{CMD_RUN, CMD_ENSRC, CMD_VFMT, CMD_VOUT, CMD_FREQ, CMD_VIN_ON, CMD_VIN_OFF, CMD_OVF};
    v = '{16'h0080, 16'h001d, 16'h0014, 16'hbccd, 16'hf208, 16'he910, 16'he900, 16'hf000};
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 1'b0, c[i], 16'h0000);
      chk(rsp_data, v[i]);
    end
  endtask
  task automatic t_writes();
    xfer(1'b1, 1'b0, CMD_VOUT, 16'hc000);
    chk(vout_target, 16'hc000);
    xfer(1'b1, 1'b0, CMD_FREQ, 16'hf1e0);
    chk(freq_set, 16'hf1e0);
    xfer(1'b1, 1'b0, CMD_VIN_ON, 16'he970);
    xfer(1'b0, 1'b0, CMD_VIN_ON, 16'h0000);
    chk(rsp_data, 16'he970);
    chk(vin_on, 16'he970);
    xfer(1'b1, 1'b0, CMD_OVF, 16'he000);
    chk(ov_limit, 16'he000);
    xfer(1'b1, 1'b0, CMD_ENSRC, 16'hab1f);
    chk({8'h00, enable_cfg}, 16'h001f);
  endtask
  // device refusals answer nak, host refusals never reach the link
  task automatic t_refuse();
    logic w [9];
    logic [7:0] c [9];
    logic [15:0] d [9];
    logic [1:0] e [9];
    w = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    c = '{CMD_VOUT, CMD_FREQ, CMD_FREQ, CMD_VIN_OFF, CMD_VFMT, 8'h2a, CMD_SAVE, CMD_VIN_OFF,
      CMD_OVF};
    d = '{16'h9999, 16'hf231, 16'h0208, 16'hf100, 16'h0014, 16'h0000, 16'h0000, 16'he961,
      16'hc000};
    e = '{2'b01, 2'b01, 2'b01, 2'b01, 2'b01, 2'b01, 2'b01, 2'b10, 2'b10};
    for (int i = 0; i < 9; i++) begin
      xfer(w[i], 1'b0, c[i], d[i]);
      chk({14'h0, rsp_refused, rsp_nak}, {14'h0, e[i]});
    end
    chk(vout_target, 16'hc000);
    chk(freq_set, 16'hf1e0);
    chk(vin_off, 16'he900);
    chk({8'h00, fault_flags}, 16'h0080);
  endtask
  task automatic t_faults();
    fault_evt = 7'h01;
    @(posedge core_clk);
    #1;
    fault_evt = 7'h00;
    chk({8'h00, fault_flags}, 16'h0081);
    xfer(1'b0, 1'b1, CMD_CLRF, 16'h0000);
    chk({15'h0, rsp_nak}, 16'h0000);
    chk({8'h00, fault_flags}, 16'h0000);
  endtask
  task automatic t_flash();
    xfer(1'b1, 1'b0, CMD_RUN, 16'h0000);
    xfer(1'b0, 1'b1, CMD_SAVE, 16'h0000);
    xfer(1'b1, 1'b0, CMD_RUN, 16'h0055);
    xfer(1'b1, 1'b0, CMD_VOUT, 16'hd333);
    chk({8'h00, run_ctrl}, 16'h0055);
    power_running = 1'b1;
    xfer(1'b0, 1'b1, CMD_RELOAD, 16'h0000);
    chk({14'h0, rsp_refused, rsp_nak}, 16'h0002);
    chk({8'h00, run_ctrl}, 16'h0055);
    power_running = 1'b0;
    xfer(1'b0, 1'b1, CMD_RELOAD, 16'h0000);
    chk({8'h00, run_ctrl}, 16'h0000);
    chk(vout_target, 16'hc000);
  endtask
  // a request held while the host is busy must not be taken a second time
  task automatic t_busy();
    {cmd_valid, cmd_wr, cmd_send, cmd_code, cmd_data} = {1'b1, 1'b0, 1'b0, CMD_OVF, 16'h0000};
    @(posedge core_clk);
    #1;
    chk({15'h0, cmd_ready}, 16'h0000);
    cmd_wr = 1'b1;
    cmd_code = CMD_RUN;
    cmd_data = 16'h0033;
    @(posedge core_clk);
    #1;
    chk({15'h0, cmd_ready}, 16'h0000);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    chk({cmd_ready, rsp_valid, rsp_nak, 13'h0}, 16'hc000);
    chk(rsp_data, 16'he000);
    repeat (2) @(posedge core_clk);
    #1;
    chk({8'h00, run_ctrl}, 16'h0000);
    chk(ov_limit, 16'he000);
  endtask
  task automatic t_strap();
    pos_logic_strap = 1'b1;
    do_reset();
    chk({enable_cfg, run_ctrl}, 16'h1f80);
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_writes();
    t_refuse();
    t_faults();
    t_flash();
    t_busy();
    t_strap();
    stop_test();
  end
  // about 100 cycles of traffic expected
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule
